// ===== inc/adcc_params.svh
// Constants of the converter control block: register indices, field positions,
// reset values, sampling counts and resolution widths.
// Included by adcc_ctrl_top; holds definitions only.
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define ADCC_IDX_CTRL_A      3'h0
`define ADCC_IDX_CTRL_B      3'h1
`define ADCC_IDX_CTRL_C      3'h2
`define ADCC_IDX_FLAGS       3'h3
`define ADCC_IDX_RES_HIGH    3'h4
`define ADCC_IDX_RES_LOW     3'h5
`define ADCC_IDX_THRESH      3'h6
`define ADCC_IDX_LAST        3'h6

// Fields of converter_control_a.
`define ADCC_A_OVR_IE        7
`define ADCC_A_RES_LSB       5
`define ADCC_A_WATCH_IE      4
`define ADCC_A_DONE_IE       3
`define ADCC_A_REPEAT        2
`define ADCC_A_START         1
`define ADCC_A_ON            0

// Fields of converter_control_b and converter_control_c.
`define ADCC_B_HALVE         7
`define ADCC_B_EDGE_LSB      5
`define ADCC_B_SRC_LSB       3
`define ADCC_B_SMP_LSB       0
`define ADCC_C_SMP_LSB       5
`define ADCC_C_WCH_LSB       0

// Bits of converter_flags.
`define ADCC_F_OVR           2
`define ADCC_F_WATCH         1
`define ADCC_F_DONE          0

// Threshold register layout.
`define ADCC_T_HI_LSB        0
`define ADCC_T_LO_LSB        16

// Reset values.
`define ADCC_RST_CTRL_A      8'h00
`define ADCC_RST_CTRL_B      8'h00
`define ADCC_RST_CTRL_C      8'h1F
`define ADCC_RST_FLAGS       3'h0
`define ADCC_RST_THRESH_HI   12'hFFF
`define ADCC_RST_THRESH_LO   12'h000

// Sampling counts in converter clocks for codes 000 to 111.
`define ADCC_SMP_0           9'h004
`define ADCC_SMP_1           9'h009
`define ADCC_SMP_2           9'h010
`define ADCC_SMP_3           9'h018
`define ADCC_SMP_4           9'h030
`define ADCC_SMP_5           9'h060
`define ADCC_SMP_6           9'h0C0
`define ADCC_SMP_7           9'h180

// First channel code that uses the auxiliary sampling field.
`define ADCC_CH_AUX_FIRST    5'h18

// Result widths in bits for resolution codes 00 to 11.
`define ADCC_RES_BITS_0      4'hC
`define ADCC_RES_BITS_1      4'hA
`define ADCC_RES_BITS_2      4'h8
`define ADCC_RES_BITS_3      4'h6

`endif

// ===== inc/adcc_pkg.sv
// Types shared by the converter control block and its conversion engine.
// Assumes nothing of its surroundings.
package adcc_pkg;

    // Conversion engine states.
    typedef enum logic [2:0] {
        ADCC_IDLE    = 3'b001,
        ADCC_SAMPLE  = 3'b010,
        ADCC_CONVERT = 3'b100
    } adcc_eng_state_t;

    // All state of the conversion engine.
    typedef struct packed {
        adcc_eng_state_t st;
        logic [8:0]      cnt;
        logic [11:0]     shift;
        logic [11:0]     result;
        logic            done;
    } adcc_eng_regs_t;

    // All state of the control and status front end.
    typedef struct packed {
        logic [7:0]  ctrl_a;
        logic [7:0]  ctrl_b;
        logic [7:0]  ctrl_c;
        logic [2:0]  flags;
        logic [7:0]  low_shadow;
        logic        shadow_valid;
        logic [11:0] thresh_hi;
        logic [11:0] thresh_lo;
        logic [2:0]  trig_meta;
        logic [2:0]  trig_sync;
        logic [2:0]  trig_prev;
        logic        halve_tgl;
        logic        dma_pend;
        logic [31:0] rdata;
    } adcc_ctl_regs_t;

endpackage

// ===== inc/adcc_conv_if.sv
// Carrier between the control front end and the conversion engine.
// Both ends run on the same clock; no crossing is involved.
`timescale 1ns/1ps
`default_nettype none

interface adcc_conv_if;
    logic        run_en;         // Engine allowed to run.
    logic        ce;             // Converter clock enable.
    logic        start;          // Start request, held for one converter clock.
    logic [8:0]  sample_cycles;  // Sampling length in converter clocks.
    logic [3:0]  res_bits;       // Bits to shift in.
    logic        busy;
    logic        done;           // One-cycle pulse at conversion end.
    logic [11:0] result;

    modport ctl (output run_en, ce, start, sample_cycles, res_bits,
                 input  busy, done, result);
    modport eng (input  run_en, ce, start, sample_cycles, res_bits,
                 output busy, done, result);
endinterface

`default_nettype wire

// ===== src/adcc_conv_engine.sv
// Conversion engine: samples for a set count, then shifts in the result
// bits that the analog core delivers serially, most significant first.
// Assumes core_bit comes from logic on mclk and is valid on each enable.
`timescale 1ns/1ps
`default_nettype none

module adcc_conv_engine
    import adcc_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  rst_n,
    adcc_conv_if.eng   cv,
    input  wire logic  core_bit,
    output logic       core_sample,
    output logic       core_convert
);

    localparam adcc_eng_regs_t ENG_RST = '{st: ADCC_IDLE, cnt: 9'h000,
        shift: 12'h000, result: 12'h000, done: 1'b0};

    adcc_eng_regs_t q;
    adcc_eng_regs_t d;

    // Next state; leaving run drops any conversion so power-down is clean.
    always_comb begin
        d      = q;
        d.done = 1'b0;
        if (!cv.run_en) begin
            d.st  = ADCC_IDLE;
            d.cnt = 9'h000;
        end else if (cv.ce) begin
            unique case (q.st)
                ADCC_IDLE: begin
                    if (cv.start) begin
                        d.st    = ADCC_SAMPLE;
                        d.cnt   = cv.sample_cycles - 9'h001;
                        d.shift = 12'h000;
                    end
                end
                ADCC_SAMPLE: begin
                    if (q.cnt == 9'h000) begin
                        d.st  = ADCC_CONVERT;
                        d.cnt = {5'h00, cv.res_bits} - 9'h001;
                    end else begin
                        d.cnt = q.cnt - 9'h001;
                    end
                end
                ADCC_CONVERT: begin
                    d.shift = {q.shift[10:0], core_bit};
                    if (q.cnt == 9'h000) begin
                        d.st     = ADCC_IDLE;
                        d.result = {q.shift[10:0], core_bit};
                        d.done   = 1'b1;
                    end else begin
                        d.cnt = q.cnt - 9'h001;
                    end
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= ENG_RST;
        end else begin
            q <= d;
        end
    end

    assign cv.busy      = (q.st != ADCC_IDLE);
    assign cv.done      = q.done;
    assign cv.result    = q.result;
    assign core_sample  = (q.st == ADCC_SAMPLE);
    assign core_convert = (q.st == ADCC_CONVERT);

endmodule // adcc_conv_engine

`default_nettype wire

// ===== src/adcc_ctrl_top.sv
// Control and status front end of a 12-bit converter, reached over APB.
// Assumes a DMA controller acknowledges results on dma_ack, a scan sequencer
// supplies the current channel and last-channel mark, and the power manager
// drives halt_mode on mclk.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_params.svh"

module adcc_ctrl_top
    import adcc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [2:0]        ext_trig,
    input  wire logic              halt_mode,
    input  wire logic [4:0]        seq_channel,
    input  wire logic              seq_last,
    input  wire logic              dma_ack,
    output logic                   dma_req,
    input  wire logic              core_bit,
    output logic                   core_power_on,
    output logic                   core_sample,
    output logic                   core_convert,
    output logic                   irq,
    output logic                   wake_req
);

    localparam adcc_ctl_regs_t CTL_RST = '{
        ctrl_a:       `ADCC_RST_CTRL_A,
        ctrl_b:       `ADCC_RST_CTRL_B,
        ctrl_c:       `ADCC_RST_CTRL_C,
        flags:        `ADCC_RST_FLAGS,
        low_shadow:   8'h00,
        shadow_valid: 1'b0,
        thresh_hi:    `ADCC_RST_THRESH_HI,
        thresh_lo:    `ADCC_RST_THRESH_LO,
        trig_meta:    3'h0,
        trig_sync:    3'h0,
        trig_prev:    3'h0,
        halve_tgl:    1'b0,
        dma_pend:     1'b0,
        rdata:        32'h0000_0000
    };

    adcc_ctl_regs_t q;
    adcc_ctl_regs_t d;
    adcc_conv_if    cv ();

    logic        conv_on;
    logic        run_en;
    logic [1:0]  res_sel;
    logic [1:0]  edge_sel;
    logic [1:0]  src_sel;
    logic [4:0]  watch_ch;
    logic [2:0]  smp_code;
    logic [2:0]  rise;
    logic [2:0]  fall;
    logic        trig_hit;
    logic        ce;
    logic [2:0]  idx;
    logic        addr_ok;
    logic        acc_wr;
    logic        acc_rd;
    logic [7:0]  high_view;
    logic [7:0]  low_view;
    logic [2:0]  enabled;
    logic        watch_out;

    // Field views of the control registers.
    assign conv_on  = q.ctrl_a[`ADCC_A_ON];
    assign res_sel  = q.ctrl_a[`ADCC_A_RES_LSB +: 2];
    assign edge_sel = q.ctrl_b[`ADCC_B_EDGE_LSB +: 2];
    assign src_sel  = q.ctrl_b[`ADCC_B_SRC_LSB +: 2];
    assign watch_ch = q.ctrl_c[`ADCC_C_WCH_LSB +: 5];

    // Halt modes stop the interface; wait modes leave it running.
    assign run_en = conv_on & ~halt_mode;

    // Converter clock enable: every cycle, or every second cycle when halved.
    assign ce = ~q.ctrl_b[`ADCC_B_HALVE] | q.halve_tgl;

    // Upper channels, reference and sensor use the auxiliary sampling field.
    assign smp_code = (seq_channel >= `ADCC_CH_AUX_FIRST)
                    ? q.ctrl_c[`ADCC_C_SMP_LSB +: 3]
                    : q.ctrl_b[`ADCC_B_SMP_LSB +: 3];

    // Sampling length lookup, shared by both sampling fields.
    always_comb begin
        unique case (smp_code)
            3'h0: cv.sample_cycles = `ADCC_SMP_0;
            3'h1: cv.sample_cycles = `ADCC_SMP_1;
            3'h2: cv.sample_cycles = `ADCC_SMP_2;
            3'h3: cv.sample_cycles = `ADCC_SMP_3;
            3'h4: cv.sample_cycles = `ADCC_SMP_4;
            3'h5: cv.sample_cycles = `ADCC_SMP_5;
            3'h6: cv.sample_cycles = `ADCC_SMP_6;
            3'h7: cv.sample_cycles = `ADCC_SMP_7;
        endcase
    end

    // Resolution sets how many bits the engine shifts in.
    always_comb begin
        unique case (res_sel)
            2'h0: cv.res_bits = `ADCC_RES_BITS_0;
            2'h1: cv.res_bits = `ADCC_RES_BITS_1;
            2'h2: cv.res_bits = `ADCC_RES_BITS_2;
            2'h3: cv.res_bits = `ADCC_RES_BITS_3;
        endcase
    end

    // Result views. Masking keeps stale upper bits out even if the width
    // was changed after the last conversion.
    always_comb begin
        unique case (res_sel)
            2'h0: high_view = {4'h0, cv.result[11:8]};
            2'h1: high_view = {6'h00, cv.result[9:8]};
            default: high_view = 8'h00;
        endcase
        low_view = (res_sel == 2'h3) ? {2'h0, cv.result[5:0]} : cv.result[7:0];
    end

    // Edge detection reads only the second synchroniser stage.
    assign rise = q.trig_sync & ~q.trig_prev;
    assign fall = ~q.trig_sync & q.trig_prev;

    // Only the selected trigger acts, on the selected edges; code 00 of the
    // edge field matches nothing, so a reserved setting cannot start.
    always_comb begin
        trig_hit = 1'b0;
        if (src_sel != 2'h0) begin
            trig_hit = (edge_sel[0] & rise[src_sel - 2'h1])
                     | (edge_sel[1] & fall[src_sel - 2'h1]);
        end
    end

    // Bus decode: each register is one aligned word, index times four.
    assign idx     = paddr[4:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:5] == '0)
                   && (idx <= `ADCC_IDX_LAST);
    assign acc_wr  = psel & penable & pwrite & addr_ok;
    assign acc_rd  = psel & penable & ~pwrite & addr_ok;

    // Watchdog compare on the completed value of the chosen channel.
    assign watch_out = (seq_channel == watch_ch)
                     & ((cv.result > q.thresh_hi) | (cv.result < q.thresh_lo));

    // Next state of the whole front end.
    always_comb begin
        d = q;

        // Trigger pins pass two flip-flops before anything looks at them.
        d.trig_meta = ext_trig;
        d.trig_sync = q.trig_meta;
        d.trig_prev = q.trig_sync;
        d.halve_tgl = ~q.halve_tgl;

        // Read data is captured in the setup phase so it is steady in access.
        if (psel && !penable) begin
            d.rdata = 32'h0000_0000;
            if (addr_ok) begin
                unique case (idx)
                    `ADCC_IDX_CTRL_A:   d.rdata[7:0] = q.ctrl_a;
                    `ADCC_IDX_CTRL_B:   d.rdata[7:0] = q.ctrl_b;
                    `ADCC_IDX_CTRL_C:   d.rdata[7:0] = q.ctrl_c;
                    `ADCC_IDX_FLAGS:    d.rdata[7:0] = {5'h00, q.flags};
                    `ADCC_IDX_RES_HIGH: d.rdata[7:0] = high_view;
                    `ADCC_IDX_RES_LOW:  d.rdata[7:0] = q.shadow_valid
                                                     ? q.low_shadow : low_view;
                    `ADCC_IDX_THRESH:   d.rdata = {4'h0, q.thresh_lo, 4'h0, q.thresh_hi};
                    default:            d.rdata = 32'h0000_0000;
                endcase
            end
        end

        // The start bit lives for exactly one converter clock.
        if (ce && q.ctrl_a[`ADCC_A_START]) begin
            d.ctrl_a[`ADCC_A_START] = 1'b0;
        end

        // Register writes take effect at the access edge.
        if (acc_wr) begin
            unique case (idx)
                `ADCC_IDX_CTRL_A: begin
                    d.ctrl_a = {pwdata[7:2], d.ctrl_a[`ADCC_A_START], pwdata[0]};
                    // A start while converting is dropped, not queued.
                    if (pwdata[`ADCC_A_START] && pwdata[`ADCC_A_ON]
                        && !halt_mode && !cv.busy) begin
                        d.ctrl_a[`ADCC_A_START] = 1'b1;
                    end
                end
                `ADCC_IDX_CTRL_B: d.ctrl_b = pwdata[7:0];
                `ADCC_IDX_CTRL_C: d.ctrl_c = pwdata[7:0];
                // Writing zero clears a flag, writing one leaves it alone.
                `ADCC_IDX_FLAGS:  d.flags = q.flags & pwdata[2:0];
                `ADCC_IDX_THRESH: begin
                    d.thresh_hi = pwdata[`ADCC_T_HI_LSB +: 12];
                    d.thresh_lo = pwdata[`ADCC_T_LO_LSB +: 12];
                end
                default: d.flags = d.flags;
            endcase
        end

        // Reading the high byte freezes the low byte for the next read.
        if (acc_rd && idx == `ADCC_IDX_RES_HIGH) begin
            d.low_shadow   = low_view;
            d.shadow_valid = 1'b1;
        end
        if (acc_rd && idx == `ADCC_IDX_RES_LOW) begin
            d.shadow_valid           = 1'b0;
            d.flags[`ADCC_F_DONE]    = 1'b0;
        end

        // A pending trigger edge launches only an idle, powered converter.
        if (trig_hit && run_en && !cv.busy) begin
            d.ctrl_a[`ADCC_A_START] = 1'b1;
        end

        // Repeat mode relaunches as soon as a conversion ends.
        if (cv.done && q.ctrl_a[`ADCC_A_REPEAT] && run_en) begin
            d.ctrl_a[`ADCC_A_START] = 1'b1;
        end

        // DMA bookkeeping; an acknowledge in the done cycle still counts.
        d.dma_pend = (q.dma_pend & ~dma_ack) | cv.done;

        // Hardware sets come after flag writes and result reads so a set beats those clears.
        if (cv.done) begin
            if (q.dma_pend && !dma_ack) begin
                d.flags[`ADCC_F_OVR] = 1'b1;
            end
            if (watch_out) begin
                d.flags[`ADCC_F_WATCH] = 1'b1;
            end
            if (seq_last) begin
                d.flags[`ADCC_F_DONE] = 1'b1;
            end
        end

        // Power-down clears every flag and any waiting start.
        if (!d.ctrl_a[`ADCC_A_ON]) begin
            d.flags                 = 3'h0;
            d.ctrl_a[`ADCC_A_START] = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= CTL_RST;
        end else begin
            q <= d;
        end
    end

    // Engine controls.
    assign cv.run_en = run_en;
    assign cv.ce     = ce;
    assign cv.start  = q.ctrl_a[`ADCC_A_START];

    adcc_conv_engine u_engine (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .cv           (cv.eng),
        .core_bit     (core_bit),
        .core_sample  (core_sample),
        .core_convert (core_convert)
    );

    // Interrupt request: each flag gated by its own enable.
    assign enabled[`ADCC_F_OVR]   = q.flags[`ADCC_F_OVR]
                                  & q.ctrl_a[`ADCC_A_OVR_IE];
    assign enabled[`ADCC_F_WATCH] = q.flags[`ADCC_F_WATCH]
                                  & q.ctrl_a[`ADCC_A_WATCH_IE];
    assign enabled[`ADCC_F_DONE]  = q.flags[`ADCC_F_DONE]
                                  & q.ctrl_a[`ADCC_A_DONE_IE];
    assign irq      = |enabled;
    // Wake only out of wait modes; in halt the request is held back.
    assign wake_req = irq & ~halt_mode;

    // Remaining outputs; the slave never inserts wait states.
    assign core_power_on = run_en;
    assign dma_req       = q.dma_pend;
    assign prdata        = q.rdata;
    assign pready        = 1'b1;
    assign pslverr       = psel & penable & ~addr_ok;

endmodule // adcc_ctrl_top

`default_nettype wire

// ===== bench/adcc_far_model.sv
// DMA controller and analog core standing at the far side of the block.
// Assumes dma_req and core_convert are launched on mclk by the block.
`timescale 1ns/1ps
`default_nettype none
module adcc_far_model (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic dma_en,
    input  wire logic bit_val,
    input  wire logic dma_req,
    input  wire logic core_convert,
    output logic      dma_ack,
    output logic      core_bit
);
    // One acknowledge per request; held off while disabled so results pile up.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) dma_ack <= 1'b0;
        else dma_ack <= dma_en && dma_req && !dma_ack;
    end
    // Outside the shifting phase the bit is inverted, so a stray sample shows.
    assign core_bit = core_convert ? bit_val : !bit_val;
endmodule // adcc_far_model
`default_nettype wire

// ===== bench/adcc_checker.sv
// Port checker of the converter control front end.
// Bound into adcc_ctrl_top; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module adcc_checker #(parameter int ADDR_W = 8) (
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic              halt_mode,
    input wire logic              dma_ack,
    input wire logic              dma_req,
    input wire logic              core_power_on,
    input wire logic              core_sample,
    input wire logic              irq,
    input wire logic              wake_req
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic rd;
    // Read data is only meaningful in a read access phase.
    assign rd = psel && penable && !pwrite;
    wake_gate_a: assert property (wake_req == (irq && !halt_mode)) else $error("wake");
    halt_off_a: assert property (halt_mode |-> !core_power_on) else $error("halt");
    sample_min_a: assert property ($rose(core_sample) |-> (core_sample || !core_power_on)[*4])
        else $error("smp");
    flag_zero_a: assert property (rd && paddr == 8'h0C |-> prdata[7:3] == 5'h00) else $error("sr");
    high_zero_a: assert property (rd && paddr == 8'h10 |-> prdata[7:4] == 4'h0) else $error("dh");
    bad_addr_a: assert property (psel && penable && paddr > 8'h18 |-> pslverr) else $error("addr");
    ack_clear_a: assert property (dma_ack |=> !dma_req) else $error("dma");
    off_quiet_a: assert property (!core_power_on && !halt_mode |=> !irq) else $error("off");
endmodule // adcc_checker
bind adcc_ctrl_top adcc_checker #(.ADDR_W(ADDR_W)) adcc_checker_i (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pslverr(pslverr), .halt_mode(halt_mode), .dma_ack(dma_ack), .dma_req(dma_req),
    .core_power_on(core_power_on), .core_sample(core_sample), .irq(irq), .wake_req(wake_req));
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench of the converter control front end over APB.
// Assumes the far model answers DMA requests and serves result bits.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        halt_mode = 1'b0, dma_en = 1'b1, pready, pslverr, dma_req, dma_ack;
    logic        core_bit, pwr, smp, cnv, irq, wake_req, seq_last = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [4:0]  seq_channel = 5'h00;
    logic [2:0]  ext_trig = 3'h0;
    int          bad_count = 0, cmp_count = 0, n = 0;
    int          tb_n [4] = '{4, 384, 8, 16};
    logic [31:0] tb_b [4] = '{32'h00, 32'h07, 32'h80, 32'h00};
    adcc_ctrl_top adcc_ctrl_top_i (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_trig(ext_trig), .halt_mode(halt_mode), .seq_last(seq_last),
        .seq_channel(seq_channel), .dma_ack(dma_ack), .dma_req(dma_req), .core_bit(core_bit),
        .core_power_on(pwr), .core_sample(smp), .core_convert(cnv), .irq(irq), .wake_req(wake_req));
    adcc_far_model adcc_far_model_i (.mclk(mclk), .rst_n(rst_n), .dma_en(dma_en), .bit_val(1'b1),
        .dma_req(dma_req), .core_convert(cnv), .dma_ack(dma_ack), .core_bit(core_bit));
    // Clock of 4 ns; sampling cycles are counted beside it.
    always #2 mclk = ~mclk;
    always @(posedge mclk) if (smp === 1'b1) n <= n + 1;
    task automatic final_report();
        $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo();
        bad_count++;
        $display("ERROR %0t: no answer in time", $time);
        final_report();
    endtask
    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) tmo();
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // Waits, bounded, until a result is offered to the DMA.
    task automatic wait_req();
        for (int k = 0; k < 3000 && dma_req !== 1'b1; k++) @(posedge mclk);
        if (dma_req !== 1'b1) tmo();
    endtask
    task automatic conv(input logic [7:0] a);
        n = 0;
        apb(1'b1, 8'h00, {24'h0, a});
        wait_req();
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        // Reset values, then an unmapped place that must read zero.
        rdc(8'h00, 32'h00);
        rdc(8'h04, 32'h00);
        rdc(8'h08, 32'h1F);
        rdc(8'h0C, 32'h00);
        rdc(8'h10, 32'h00);
        rdc(8'h1C, 32'h00);
        $display("test reset done");
        // Sampling per code and channel group, and with the clock halved.
        for (int i = 0; i < 4; i++) begin
            seq_channel <= (i == 3) ? 5'h18 : 5'h00;
            apb(1'b1, 8'h04, tb_b[i]);
            apb(1'b1, 8'h08, 32'h5F);
            conv(8'h63);
            chk(32'(n), 32'(tb_n[i]));
        end
        chk({31'h0, irq}, 32'h0);
        $display("test sampling done");
        // Alignment at every resolution; the low byte is read after the high one.
        for (int r = 0; r < 4; r++) begin
            conv(8'h0B | 8'(r << 5));
            chk({31'h0, irq}, 32'h1);
            rdc(8'h00, 32'h09 | 32'(r << 5));
            rdc(8'h10, (r == 0) ? 32'h0F : (r == 1) ? 32'h03 : 32'h00);
            rdc(8'h14, (r == 3) ? 32'h3F : 32'hFF);
            rdc(8'h0C, 32'h00);
        end
        $display("test resolution done");
        // Watchdog on channel 24 mid-scan; a start written while busy is dropped.
        seq_last <= 1'b0;
        apb(1'b1, 8'h18, 32'h800);
        rdc(8'h18, 32'h800);
        apb(1'b1, 8'h08, 32'h58);
        n = 0;
        apb(1'b1, 8'h00, 32'h13);
        apb(1'b1, 8'h00, 32'h13);
        wait_req();
        chk({31'h0, irq}, 32'h1);
        rdc(8'h0C, 32'h02);
        chk(32'(n), 32'h10);
        apb(1'b1, 8'h0C, 32'h05);
        rdc(8'h0C, 32'h00);
        chk({31'h0, irq}, 32'h0);
        seq_last <= 1'b1;
        apb(1'b1, 8'h18, 32'hFFF);
        $display("test watchdog done");
        // Each trigger source with its own edge code; the falling one skips a rise.
        apb(1'b1, 8'h00, 32'h61);
        for (int i = 1; i < 4; i++) begin
            apb(1'b1, 8'h04, 32'((i << 5) | (i << 3)));
            ext_trig[i-1] <= 1'b1;
            repeat (6) @(posedge mclk);
            if (i == 2) chk({31'h0, dma_req}, 32'h0);
            if (i == 2) ext_trig[1] <= 1'b0;
            wait_req();
        end
        $display("test triggers done");
        // Results pile up in repeat mode while the DMA stays off.
        dma_en <= 1'b0;
        apb(1'b1, 8'h00, 32'h87);
        for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge mclk);
        if (irq !== 1'b1) tmo();
        rdc(8'h0C, 32'h05);
        halt_mode <= 1'b1;
        repeat (4) @(posedge mclk);
        chk({29'h0, pwr, irq, wake_req}, 32'h2);
        halt_mode <= 1'b0;
        repeat (4) @(posedge mclk);
        chk({29'h0, pwr, irq, wake_req}, 32'h7);
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b1, 8'h0C, 32'h07);
        rdc(8'h0C, 32'h00);
        chk({30'h0, pwr, irq}, 32'h0);
        $display("test overrun done");
        final_report();
    end
endmodule // testbench
`default_nettype wire
